// *** design/isc_consts.svh ***
`ifndef ISC_CONSTS_SVH
`define ISC_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define ISC_OFF_CTRL     8'h00
`define ISC_OFF_PFLAG_A  8'h04
`define ISC_OFF_PFLAG_B  8'h08
`define ISC_OFF_PEN_A    8'h0C
`define ISC_OFF_PEN_B    8'h10
`define ISC_OFF_OPTION   8'h14
`define ISC_OFF_CORE     8'h18

// ---------------------------------------------------------------
// control and option register bit positions
// ---------------------------------------------------------------
`define ISC_BIT_PCF      0
`define ISC_BIT_EXF      1
`define ISC_BIT_T0F      2
`define ISC_BIT_PCE      3
`define ISC_BIT_EXE      4
`define ISC_BIT_T0E      5
`define ISC_BIT_PEIE     6
`define ISC_BIT_GIE      7
`define ISC_BIT_EDGE     6

// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define ISC_CTRL_RST     8'h00
`define ISC_OPTION_RST   8'hFF
`define ISC_VECTOR       13'h0004

`endif

// *** design/isc_irq_ctrl.sv ***
// Summary of operation
// - nineteen sources, each with its own flag and its own enable bit
// - flags set on their event regardless of own or global enable
// - global enable, control bit 7, permits or blocks all vectoring
// - global enable plus any flag and enable pair requests vector at once; peripheral pairs also need bit 6
// - every reset clears the global enable
// - return-from-interrupt instruction sets the global enable again
// - on entry clear global enable, push return address, vector to 0004h
// - pin and port-change latency to vector is four or five cycles
// - external pin edge: rising when option bit 6 set, else falling
// - valid pin edge sets control bit 1; bit 4 masks it
// - pin interrupt wakes sleep only if enabled; global enable decides whether it then vectors
// - timer0 wrap FFh to 00h sets control bit 2; bit 5 gates it
// - change on port b pins 7 to 4 sets control bit 0, own enable
// - pin, port-change and timer0 flags and enables in control register
// - peripheral flags and enables in two register pairs, one gate bit
// - hardware saves only the return counter on entry
// - enabled flagged source wakes sleep whatever global enable says
`timescale 1ns/100ps
`default_nettype none
`include "isc_consts.svh"
module isc_irq_ctrl
  import isc_pkg::*;
#(
  parameter int PC_W = 13
) (
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // axi4-lite write address
  input  wire logic [7:0]      s_axi_awaddr,
  input  wire logic            s_axi_awvalid,
  output logic                 s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]     s_axi_wdata,
  input  wire logic [3:0]      s_axi_wstrb,
  input  wire logic            s_axi_wvalid,
  output logic                 s_axi_wready,
  // axi4-lite write response
  output logic [1:0]           s_axi_bresp,
  output logic                 s_axi_bvalid,
  input  wire logic            s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]      s_axi_araddr,
  input  wire logic            s_axi_arvalid,
  output logic                 s_axi_arready,
  // axi4-lite read data
  output logic [31:0]          s_axi_rdata,
  output logic [1:0]           s_axi_rresp,
  output logic                 s_axi_rvalid,
  input  wire logic            s_axi_rready,
  // pins and events
  input  wire logic            ext_irq_pin,
  input  wire logic [3:0]      port_b_pins,
  input  wire logic [7:0]      timer0_count,
  input  wire logic [7:0]      periph_evt_a,
  input  wire logic [7:0]      periph_evt_b,
  // core sequencer
  input  wire logic [PC_W-1:0] core_pc,
  input  wire logic            core_sleeping,
  input  wire logic            return_from_irq_instr,
  output logic                 irq_request,
  output logic                 vector_take,
  output logic [PC_W-1:0]      vector_pc,
  output logic                 stack_push,
  output logic [PC_W-1:0]      stack_push_data,
  output logic                 wake_up
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  isc_byte_t  interrupt_control_reg;
  isc_byte_t  periph_flag_reg_a;
  isc_byte_t  periph_flag_reg_b;
  isc_byte_t  periph_enable_reg_a;
  isc_byte_t  periph_enable_reg_b;
  isc_byte_t  option_reg;
  isc_byte_t  tmr_prev_reg;
  isc_state_e state_reg;
  isc_state_e state_next;
  logic       vec_reg;
  logic [PC_W-1:0] push_data_reg;
  logic       awv_reg;
  logic       wv_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic       bvalid_reg;
  logic       rvalid_reg;
  logic [31:0] rdata_reg;

  // ---------------------------------------------------------------
  // pin synchroniser and event detection
  // ---------------------------------------------------------------
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;

  isc_pin_sync #(.WIDTH(5)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   ({port_b_pins, ext_irq_pin}),
    .pin_sync (pin_sync),
    .pin_prev (pin_prev)
  );

  wire edge_sel   = option_reg[`ISC_BIT_EDGE];
  wire ext_rise   = pin_sync[0] & ~pin_prev[0];
  wire ext_fall   = ~pin_sync[0] & pin_prev[0];
  wire ext_evt    = edge_sel ? ext_rise : ext_fall;
  wire port_evt   = |(pin_sync[4:1] ^ pin_prev[4:1]);
  wire tmr_evt    = (tmr_prev_reg == 8'hFF) &&
                    (timer0_count == 8'h00);

  // ---------------------------------------------------------------
  // bus write decode
  // ---------------------------------------------------------------
  wire wr_fire  = awv_reg & wv_reg & ~bvalid_reg;
  wire wr_lane0 = wr_fire & wstrb_reg[0];
  wire wr_ctrl  = wr_lane0 && (awaddr_reg == `ISC_OFF_CTRL);
  wire wr_pfa   = wr_lane0 && (awaddr_reg == `ISC_OFF_PFLAG_A);
  wire wr_pfb   = wr_lane0 && (awaddr_reg == `ISC_OFF_PFLAG_B);
  wire wr_pea   = wr_lane0 && (awaddr_reg == `ISC_OFF_PEN_A);
  wire wr_peb   = wr_lane0 && (awaddr_reg == `ISC_OFF_PEN_B);
  wire wr_opt   = wr_lane0 && (awaddr_reg == `ISC_OFF_OPTION);
  wire [7:0] wbyte = wdata_reg[7:0];

  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `ISC_OFF_CTRL) || (a == `ISC_OFF_PFLAG_A) ||
              (a == `ISC_OFF_PFLAG_B) || (a == `ISC_OFF_PEN_A) ||
              (a == `ISC_OFF_PEN_B) || (a == `ISC_OFF_OPTION) ||
              (a == `ISC_OFF_CORE);
  endfunction : addr_ok

  // ---------------------------------------------------------------
  // request combination
  // ---------------------------------------------------------------
  wire [7:0] ic = interrupt_control_reg;
  wire core_pend  = (ic[`ISC_BIT_EXF] & ic[`ISC_BIT_EXE]) |
                    (ic[`ISC_BIT_T0F] & ic[`ISC_BIT_T0E]) |
                    (ic[`ISC_BIT_PCF] & ic[`ISC_BIT_PCE]);
  wire per_pend   = ic[`ISC_BIT_PEIE] &
                    (|(periph_flag_reg_a & periph_enable_reg_a) |
                     |(periph_flag_reg_b & periph_enable_reg_b));
  wire any_pend   = core_pend | per_pend;
  wire req        = any_pend & ic[`ISC_BIT_GIE];
  wire take       = (state_reg == ISC_RUN) && !core_sleeping &&
                    req;

  // ---------------------------------------------------------------
  // control register next value
  // ---------------------------------------------------------------
  isc_byte_t ctrl_next;
  always_comb begin
    ctrl_next = wr_ctrl ? wbyte : interrupt_control_reg;
    if (ext_evt)
      ctrl_next[`ISC_BIT_EXF] = 1'b1;
    if (tmr_evt)
      ctrl_next[`ISC_BIT_T0F] = 1'b1;
    if (port_evt)
      ctrl_next[`ISC_BIT_PCF] = 1'b1;
    if (return_from_irq_instr)
      ctrl_next[`ISC_BIT_GIE] = 1'b1;
    if (take)
      ctrl_next[`ISC_BIT_GIE] = 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_control_reg <= `ISC_CTRL_RST;
      option_reg            <= `ISC_OPTION_RST;
      tmr_prev_reg          <= 8'h00;
    end else begin
      interrupt_control_reg <= ctrl_next;
      option_reg            <= wr_opt ? wbyte : option_reg;
      tmr_prev_reg          <= timer0_count;
    end
  end

  // peripheral flags: event set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_flag_reg_a   <= 8'h00;
      periph_flag_reg_b   <= 8'h00;
      periph_enable_reg_a <= 8'h00;
      periph_enable_reg_b <= 8'h00;
    end else begin
      periph_flag_reg_a   <= (wr_pfa ? wbyte : periph_flag_reg_a) |
                             periph_evt_a;
      periph_flag_reg_b   <= (wr_pfb ? wbyte : periph_flag_reg_b) |
                             periph_evt_b;
      periph_enable_reg_a <= wr_pea ? wbyte : periph_enable_reg_a;
      periph_enable_reg_b <= wr_peb ? wbyte : periph_enable_reg_b;
    end
  end

  // ---------------------------------------------------------------
  // vector sequencer
  // ---------------------------------------------------------------
  always_comb begin
    case (state_reg)
      ISC_RUN:   state_next = core_sleeping ? ISC_SLEEP :
                              (take ? ISC_WAIT : ISC_RUN);
      ISC_WAIT:  state_next = ISC_RUN;
      ISC_SLEEP: state_next = !core_sleeping ? ISC_RUN :
                              (any_pend ? ISC_RUN : ISC_SLEEP);
      default:   state_next = ISC_RUN;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg     <= ISC_RUN;
      vec_reg       <= 1'b0;
      push_data_reg <= '0;
    end else begin
      state_reg     <= state_next;
      vec_reg       <= take;
      push_data_reg <= take ? core_pc : push_data_reg;
    end
  end

  assign irq_request     = req;
  assign vector_take     = vec_reg;
  assign stack_push      = vec_reg;
  assign stack_push_data = push_data_reg;
  assign vector_pc       = PC_W'(`ISC_VECTOR);
  assign wake_up         = (state_reg == ISC_SLEEP) &
                           any_pend;

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  assign s_axi_awready = ~awv_reg;
  assign s_axi_wready  = ~wv_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;

  logic [1:0] bresp_reg;
  logic [1:0] rresp_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rresp = rresp_reg;

  wire rd_fire = s_axi_arvalid & ~rvalid_reg;
  logic [7:0] rd_byte;
  always_comb begin
    case (s_axi_araddr)
      `ISC_OFF_CTRL:    rd_byte = interrupt_control_reg;
      `ISC_OFF_PFLAG_A: rd_byte = periph_flag_reg_a;
      `ISC_OFF_PFLAG_B: rd_byte = periph_flag_reg_b;
      `ISC_OFF_PEN_A:   rd_byte = periph_enable_reg_a;
      `ISC_OFF_PEN_B:   rd_byte = periph_enable_reg_b;
      `ISC_OFF_OPTION:  rd_byte = option_reg;
      `ISC_OFF_CORE:    rd_byte = {5'h00, wake_up, req,
                                   state_reg == ISC_SLEEP};
      default:          rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awv_reg    <= 1'b0;
      wv_reg     <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= 2'b00;
    end else begin
      if (s_axi_awvalid && !awv_reg) begin
        awv_reg    <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        awv_reg <= 1'b0;
      end
      if (s_axi_wvalid && !wv_reg) begin
        wv_reg    <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        wv_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= addr_ok(awaddr_reg) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= 2'b00;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_byte};
      rresp_reg  <= addr_ok(s_axi_araddr) ? 2'b00 : 2'b10;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_GIE_RESET: assert property (@(posedge aclk)
    !$past(aresetn) |-> !interrupt_control_reg[`ISC_BIT_GIE])
    else $error("global enable not cleared by reset");
  AST_TAKE_CLEARS_GIE: assert property (@(posedge aclk)
    disable iff (!aresetn) take |=> !interrupt_control_reg[`ISC_BIT_GIE]
      && stack_push && vector_pc == PC_W'(`ISC_VECTOR))
    else $error("vector entry did not clear enable and push");
  AST_RETURN_SETS_GIE: assert property (@(posedge aclk)
    disable iff (!aresetn) return_from_irq_instr && !take
      |=> interrupt_control_reg[`ISC_BIT_GIE])
    else $error("return did not set global enable");
  AST_NO_REQ_WITHOUT_GIE: assert property (@(posedge aclk)
    disable iff (!aresetn) !interrupt_control_reg[`ISC_BIT_GIE]
      |-> !irq_request && !take)
    else $error("request with global enable clear");
  AST_REQ_IMMEDIATE: assert property (@(posedge aclk)
    disable iff (!aresetn) interrupt_control_reg[`ISC_BIT_GIE] && any_pend
      && state_reg == ISC_RUN && !core_sleeping |-> irq_request
      ##1 vector_take)
    else $error("request not raised at once");
  AST_EXT_FLAG: assert property (@(posedge aclk)
    disable iff (!aresetn) ext_evt |=> interrupt_control_reg[`ISC_BIT_EXF])
    else $error("pin edge did not set its flag");
  AST_TMR_FLAG: assert property (@(posedge aclk)
    disable iff (!aresetn) timer0_count == 8'h00 && $past(timer0_count)
      == 8'hFF |=> interrupt_control_reg[`ISC_BIT_T0F])
    else $error("timer0 wrap did not set its flag");
  AST_PORT_FLAG: assert property (@(posedge aclk)
    disable iff (!aresetn) port_evt |=> interrupt_control_reg[`ISC_BIT_PCF])
    else $error("port change did not set its flag");
  AST_LATENCY: assert property (@(posedge aclk)
    disable iff (!aresetn) ext_evt && ic[`ISC_BIT_EXE] &&
      ic[`ISC_BIT_GIE] && !wr_ctrl && state_reg == ISC_RUN &&
      !core_sleeping |-> ##[1:2] vector_take)
    else $error("vector latency out of range");
  AST_WAKE: assert property (@(posedge aclk)
    disable iff (!aresetn) state_reg == ISC_SLEEP && core_sleeping &&
      any_pend |=> state_reg == ISC_RUN)
    else $error("enabled flag did not wake from sleep");

endmodule : isc_irq_ctrl
`default_nettype wire

// *** design/isc_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module isc_pin_sync #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // pins
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync,
  output logic      [WIDTH-1:0] pin_prev
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] prev_reg;
  logic [2:0]       fill_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
      fill_reg <= 3'h0;
    end else begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      fill_reg <= {fill_reg[1:0], 1'b1};
    end
  end

  // no false edge while the chain still holds reset values
  assign pin_sync = sync_reg;
  assign pin_prev = fill_reg[2] ? prev_reg : sync_reg;
endmodule : isc_pin_sync
`default_nettype wire

// *** design/isc_pkg.sv ***
package isc_pkg;
  typedef enum logic [1:0] {
    ISC_RUN,
    ISC_WAIT,
    ISC_SLEEP
  } isc_state_e;
  typedef logic [7:0] isc_byte_t;
endpackage : isc_pkg

// *** verif/isc_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ---------------------------------------------------------------
// core sequencer model: runs, vectors, returns and sleeps
// ---------------------------------------------------------------
module isc_core_model (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // controller side
  input  wire logic        vector_take,
  input  wire logic [12:0] vector_pc,
  input  wire logic        stack_push,
  input  wire logic [12:0] stack_push_data,
  input  wire logic        wake_up,
  output logic      [12:0] core_pc,
  output logic             core_sleeping,
  output logic             return_from_irq_instr,
  // bench side
  input  wire logic        sleep_go,
  input  wire logic        ret_go,
  output int               vec_count,
  output logic      [12:0] saved_pc,
  output logic      [12:0] expect_pc
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_pc               <= 13'h0000;
      core_sleeping         <= 1'b0;
      return_from_irq_instr <= 1'b0;
      vec_count             <= 0;
      saved_pc              <= 13'h0000;
      expect_pc             <= 13'h0000;
    end else begin
      return_from_irq_instr <= ret_go;
      if (!core_sleeping) core_pc <= core_pc + 13'h0001;
      if (vector_take) begin
        core_pc   <= vector_pc;
        vec_count <= vec_count + 1;
      end
      if (stack_push) begin
        saved_pc  <= stack_push_data;
        expect_pc <= core_pc - 13'h0001;
      end
      if (return_from_irq_instr) core_pc <= saved_pc;
      if (wake_up) core_sleeping <= 1'b0;
      else if (sleep_go) core_sleeping <= 1'b1;
    end
  end
endmodule : isc_core_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "isc_consts.svh"
`define CHK(a,e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import isc_pkg::*;
  logic        aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
  logic [7:0]  awa, ara, tmr, pea, peb;
  logic [31:0] wd, rd, v;
  logic [3:0]  ws, pb;
  logic [1:0]  bresp, rresp, r;
  logic        pin, sleep_go, ret_go, irq, vt, sp, wake, slp, rfi;
  logic [12:0] cpc, vpc, spd, saved, expc;
  int          vcnt, bad_count, num_checks, ticks, c, n;

  isc_irq_ctrl #(.PC_W(13)) isc_irq_ctrl_i (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .ext_irq_pin(pin),
    .port_b_pins(pb), .timer0_count(tmr), .periph_evt_a(pea),
    .periph_evt_b(peb), .core_pc(cpc), .core_sleeping(slp),
    .return_from_irq_instr(rfi), .irq_request(irq), .vector_take(vt),
    .vector_pc(vpc), .stack_push(sp), .stack_push_data(spd),
    .wake_up(wake));

  isc_core_model isc_core_model_i (
    .aclk(aclk), .aresetn(aresetn), .vector_take(vt), .vector_pc(vpc),
    .stack_push(sp), .stack_push_data(spd), .wake_up(wake),
    .core_pc(cpc), .core_sleeping(slp), .return_from_irq_instr(rfi),
    .sleep_go(sleep_go), .ret_go(ret_go), .vec_count(vcnt),
    .saved_pc(saved), .expect_pc(expc));

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    logic ah, wh, bh;
    awa <= a; wd <= {24'h000000, d}; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    do begin
      @(negedge aclk);
      ah = awv && awr; wh = wv && wr; bh = bv && br; r = bresp;
      @(posedge aclk);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
    end while (!bh);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a);
    logic ah, rh;
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    do begin
      @(negedge aclk);
      ah = arv && arr; rh = rv && rr; v = rd; r = rresp;
      @(posedge aclk);
      if (ah) arv <= 1'b0;
    end while (!rh);
  endtask : rd_reg

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a);
    `CHK(v, {24'h000000, e})
  endtask : rchk

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_regs;
    rchk(`ISC_OFF_CTRL, 8'h00);
    rchk(`ISC_OFF_OPTION, 8'hFF);
    rd_reg(8'h1C);
    `CHK(r, 2'b10)
    wr_reg(8'h1C, 8'hFF);
    `CHK(r, 2'b10)
  endtask : t_regs

  task automatic t_timer;
    tmr <= 8'hFE; cyc(1); tmr <= 8'hFF; cyc(1); tmr <= 8'h00; cyc(3);
    rchk(`ISC_OFF_CTRL, 8'h04);
    c = vcnt;
    wr_reg(`ISC_OFF_CTRL, 8'hA4); cyc(8);
    `CHK(vcnt, c + 1)
    `CHK(saved, expc)
    `CHK(vpc, 13'h0004)
    rchk(`ISC_OFF_CTRL, 8'h24);
    wr_reg(`ISC_OFF_CTRL, 8'h20);
    ret_go <= 1'b1; cyc(1); ret_go <= 1'b0; cyc(6);
    rchk(`ISC_OFF_CTRL, 8'hA0);
    `CHK(vcnt, c + 1)
  endtask : t_timer

  task automatic t_ext;
    wr_reg(`ISC_OFF_OPTION, 8'h40);
    wr_reg(`ISC_OFF_CTRL, 8'h90);
    pin <= 1'b1; n = 0;
    do begin @(negedge aclk); n++; end while (!vt && n < 12);
    `CHK(vt, 1'b1)
    `CHK(n >= 4 && n <= 5, 1'b1)
    @(posedge aclk);
    rchk(`ISC_OFF_CTRL, 8'h12);
    wr_reg(`ISC_OFF_CTRL, 8'h10); pin <= 1'b0; cyc(6);
    rchk(`ISC_OFF_CTRL, 8'h10);
    wr_reg(`ISC_OFF_OPTION, 8'h00); pin <= 1'b1; cyc(6);
    rchk(`ISC_OFF_CTRL, 8'h10);
    pin <= 1'b0; cyc(6);
    rchk(`ISC_OFF_CTRL, 8'h12);
  endtask : t_ext

  task automatic t_port;
    wr_reg(`ISC_OFF_CTRL, 8'h00); pb <= 4'h4; cyc(6);
    rchk(`ISC_OFF_CTRL, 8'h01);
    wr_reg(`ISC_OFF_CTRL, 8'h00); cyc(6);
    rchk(`ISC_OFF_CTRL, 8'h00);
  endtask : t_port

  task automatic t_periph;
    pea <= 8'h08; peb <= 8'h01; cyc(1); pea <= 8'h00; peb <= 8'h00; cyc(2);
    rchk(`ISC_OFF_PFLAG_A, 8'h08);
    rchk(`ISC_OFF_PFLAG_B, 8'h01);
    c = vcnt;
    wr_reg(`ISC_OFF_PEN_A, 8'h08); wr_reg(`ISC_OFF_CTRL, 8'h80); cyc(8);
    `CHK(vcnt, c)
    `CHK(irq, 1'b0)
    wr_reg(`ISC_OFF_CTRL, 8'hC0); cyc(8);
    `CHK(vcnt, c + 1)
    rchk(`ISC_OFF_CTRL, 8'h40);
    wr_reg(`ISC_OFF_PFLAG_A, 8'h00); wr_reg(`ISC_OFF_PFLAG_B, 8'h00);
    rchk(`ISC_OFF_PEN_A, 8'h08);
  endtask : t_periph

  task automatic t_sleep;
    wr_reg(`ISC_OFF_OPTION, 8'h40); wr_reg(`ISC_OFF_CTRL, 8'h00);
    c = vcnt;
    sleep_go <= 1'b1; cyc(1); sleep_go <= 1'b0; cyc(1);
    pin <= 1'b1; cyc(8); @(negedge aclk);
    `CHK(slp, 1'b1)
    @(posedge aclk);
    wr_reg(`ISC_OFF_CTRL, 8'h12); cyc(4); @(negedge aclk);
    `CHK(slp, 1'b0)
    `CHK(vcnt, c)
    @(posedge aclk);
  endtask : t_sleep

  task automatic t_rst;
    wr_reg(`ISC_OFF_CTRL, 8'h80);
    rchk(`ISC_OFF_CTRL, 8'h80);
    aresetn <= 1'b0; cyc(2); aresetn <= 1'b1; cyc(1);
    rchk(`ISC_OFF_CTRL, 8'h00);
  endtask : t_rst

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    ticks <= ticks + 1;
    if (ticks == 20000) begin
      bad_count++;
      conclude;
    end
  end

  initial begin
    aresetn = 1'b0; awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0;
    rr = 1'b0; awa = 8'h00; ara = 8'h00; wd = 32'h00000000; ws = 4'h1;
    tmr = 8'h00; pea = 8'h00; peb = 8'h00; pb = 4'h0; pin = 1'b0;
    sleep_go = 1'b0; ret_go = 1'b0; ticks = 0;
    bad_count = 0; num_checks = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs; t_timer; t_ext; t_port; t_periph; t_sleep; t_rst;
    conclude;
  end
endmodule : tb
`default_nettype wire
